/* mr4_pkg.sv */
/*
 * Constants for the fourth mode register block: command pin widths,
 * register image layout, field positions, select and latency codes,
 * readback location of the repair availability bits.
 * Assumes one command clock domain and the mode-set encoding on the pins.
 */
package mr4_pkg;

	// ------------------------------------------------------------------
	// register image
	// ------------------------------------------------------------------
	localparam int MR4_IMG_W = 22;
	localparam int MR4_ADDR_W = 14;
	localparam int MR4_BG_W = 2;
	localparam int MR4_BA_W = 2;
	localparam logic [MR4_IMG_W-1:0] MR4_RESET_IMG = 22'h000000;

	localparam int MR4_B_RSV21 = 21;
	localparam int MR4_B_SEL_HI = 20;
	localparam int MR4_B_SEL_LO = 18;
	localparam int MR4_B_RSV17 = 17;
	localparam int MR4_B_PERM_REPAIR = 13;
	localparam int MR4_B_WR_LEAD = 12;
	localparam int MR4_B_RD_LEAD = 11;
	localparam int MR4_B_RD_TRAIN = 10;
	localparam int MR4_B_SR_ABORT = 9;
	localparam int MR4_B_CAL_HI = 8;
	localparam int MR4_B_CAL_LO = 6;
	localparam int MR4_B_SOFT_REPAIR = 5;
	localparam int MR4_B_VREF_MON = 4;
	localparam int MR4_B_TCR_EN = 3;
	localparam int MR4_B_TCR_RANGE = 2;
	localparam int MR4_B_MAX_PWR = 1;
	localparam int MR4_B_RSV0 = 0;

	// ------------------------------------------------------------------
	// register select codes
	// ------------------------------------------------------------------
	localparam logic [2:0] MR4_SEL_THIS = 3'h4;
	localparam logic [2:0] MR4_SEL_FORBIDDEN = 3'h7;

	// ------------------------------------------------------------------
	// command address latency codes and values in clocks
	// ------------------------------------------------------------------
	localparam int MR4_CAL_VAL_W = 4;
	localparam logic [2:0] MR4_CAL_OFF = 3'h0;
	localparam logic [2:0] MR4_CAL_C3 = 3'h1;
	localparam logic [2:0] MR4_CAL_C4 = 3'h2;
	localparam logic [2:0] MR4_CAL_C5 = 3'h3;
	localparam logic [2:0] MR4_CAL_C6 = 3'h4;
	localparam logic [2:0] MR4_CAL_C8 = 3'h5;
	localparam logic [3:0] MR4_CAL_V0 = 4'h0;
	localparam logic [3:0] MR4_CAL_V3 = 4'h3;
	localparam logic [3:0] MR4_CAL_V4 = 4'h4;
	localparam logic [3:0] MR4_CAL_V5 = 4'h5;
	localparam logic [3:0] MR4_CAL_V6 = 4'h6;
	localparam logic [3:0] MR4_CAL_V8 = 4'h8;

	// ------------------------------------------------------------------
	// readback page 2 location 0
	// ------------------------------------------------------------------
	localparam int MR4_RB_PAGE = 2;
	localparam int MR4_RB_LOC = 0;
	localparam int MR4_RB_B_PERM = 7;
	localparam int MR4_RB_B_SOFT = 6;

	// ------------------------------------------------------------------
	// pin bundle layout through the synchroniser
	// ------------------------------------------------------------------
	localparam int MR4_PIN_W = 25;
	localparam logic [MR4_PIN_W-1:0] MR4_PIN_IDLE = 25'h1f00000;

endpackage : mr4_pkg

/* mr4_sync.sv */
/*
 * Two flip-flop synchroniser for a bundle of pin inputs.
 * Assumes a synchronous active high reset; the idle value is a parameter.
 */
`timescale 1ns/1ps
module mr4_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage1_next;
	logic [W-1:0] stage2_reg;
	logic [W-1:0] stage2_next;

	initial begin
		if (W < 1) begin
			$error("mr4_sync: width must be at least one");
		end
	end

	// first stage is read only by the second stage
	always_comb begin
		stage1_next = d;
		stage2_next = stage1_reg;
		if (rst) begin
			stage1_next = RST_VAL;
			stage2_next = RST_VAL;
		end
	end

	always_ff @(posedge clk) begin
		stage1_reg <= stage1_next;
		stage2_reg <= stage2_next;
	end

	assign q = stage2_reg;

endmodule : mr4_sync

/* mr4_repair.sv */
/*
 * Row repair bookkeeping: one permanent and one soft repair slot per
 * bank group, each holding the repaired row.
 * Assumes por marks a fresh die; permanent slots survive rst.
 */
`timescale 1ns/1ps
module mr4_repair #(
	parameter int BG_N = 4,
	parameter int ROW_W = 14
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	input wire logic power_down,
	input wire logic req,
	input wire logic req_soft,
	input wire logic [$clog2(BG_N)-1:0] req_bg,
	input wire logic [ROW_W-1:0] req_row,
	output logic [BG_N-1:0] perm_mask,
	output logic [BG_N-1:0] soft_mask,
	output logic [BG_N*ROW_W-1:0] perm_rows,
	output logic [BG_N*ROW_W-1:0] soft_rows,
	output logic refused
);
	logic [BG_N-1:0] perm_mask_reg, perm_mask_next;
	logic [BG_N-1:0] soft_mask_reg, soft_mask_next;
	logic [BG_N*ROW_W-1:0] perm_rows_reg, perm_rows_next;
	logic [BG_N*ROW_W-1:0] soft_rows_reg, soft_rows_next;
	logic refused_reg, refused_next;

	initial begin
		if (BG_N < 2 || ROW_W < 1) begin
			$error("mr4_repair: unsupported bank group count or row width");
		end
	end

	always_comb begin
		perm_mask_next = perm_mask_reg;
		soft_mask_next = soft_mask_reg;
		perm_rows_next = perm_rows_reg;
		soft_rows_next = soft_rows_reg;
		refused_next = 1'b0;
		if (req && !req_soft) begin
			// a used slot refuses: one row per group, undone only by por
			if (perm_mask_reg[req_bg]) begin
				refused_next = 1'b1;
			end else begin
				perm_mask_next[req_bg] = 1'b1;
				perm_rows_next[req_bg*ROW_W +: ROW_W] = req_row;
			end
		end
		if (req && req_soft) begin
			if (soft_mask_reg[req_bg]) begin
				refused_next = 1'b1;
			end else begin
				soft_mask_next[req_bg] = 1'b1;
				soft_rows_next[req_bg*ROW_W +: ROW_W] = req_row;
			end
		end
		// soft repairs are volatile
		if (rst || power_down) begin
			soft_mask_next = '0;
			soft_rows_next = '0;
			refused_next = 1'b0;
		end
		// only a fresh die clears the permanent slots
		if (por) begin
			perm_mask_next = '0;
			perm_rows_next = '0;
			soft_mask_next = '0;
			soft_rows_next = '0;
			refused_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		perm_mask_reg <= perm_mask_next;
		soft_mask_reg <= soft_mask_next;
		perm_rows_reg <= perm_rows_next;
		soft_rows_reg <= soft_rows_next;
		refused_reg <= refused_next;
	end

	assign perm_mask = perm_mask_reg;
	assign soft_mask = soft_mask_reg;
	assign perm_rows = perm_rows_reg;
	assign soft_rows = soft_rows_reg;
	assign refused = refused_reg;

endmodule : mr4_repair

/* mr4_top.sv */
/*
 * Fourth mode register of the DRAM: decodes mode-set commands from the
 * command pins, holds the register image and drives the decoded controls,
 * the repair availability byte and the row repair bookkeeping.
 * Assumes command pins are sampled on clk through a two-stage synchroniser.
 */
`timescale 1ns/1ps
module mr4_top
	import mr4_pkg::*;
#(
	parameter logic PERM_REPAIR_AVAIL = 1'b1,
	parameter logic SOFT_REPAIR_AVAIL = 1'b1,
	parameter int BG_N = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	input wire logic pin_cs_n,
	input wire logic pin_act_n,
	input wire logic pin_ras_n,
	input wire logic pin_cas_n,
	input wire logic pin_we_n,
	input wire logic [MR4_BG_W-1:0] pin_bg,
	input wire logic [MR4_BA_W-1:0] pin_ba,
	input wire logic pin_a17,
	input wire logic [MR4_ADDR_W-1:0] pin_addr,
	input wire logic pin_power_down,
	output logic [MR4_IMG_W-1:0] mode_register_four,
	output logic permanent_row_repair,
	output logic soft_row_repair,
	output logic write_strobe_lead_two,
	output logic read_strobe_lead_two,
	output logic read_preamble_training,
	output logic self_refresh_abort,
	output logic [MR4_CAL_VAL_W-1:0] cmd_addr_latency,
	output logic cal_code_reserved,
	output logic vref_monitor,
	output logic temp_refresh,
	output logic temp_refresh_extended,
	output logic max_power_saving,
	output logic [7:0] readback_pattern_register,
	output logic load_pulse,
	output logic reserved_future_bit_seen,
	output logic forbidden_select_code_seen,
	output logic [BG_N-1:0] perm_repaired,
	output logic [BG_N-1:0] soft_repaired,
	output logic repair_refused
);

	initial begin
		if (BG_N != (1 << MR4_BG_W)) begin
			$error("mr4_top: bank group count must match the group pins");
		end
	end

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	// codes 110 and 111 fall to the reserved answer
	function automatic logic [MR4_CAL_VAL_W:0] mr4_cal_decode(input logic [2:0] code);
		logic [MR4_CAL_VAL_W:0] res;
		res = {1'b1, MR4_CAL_V0};
		case (code)
			MR4_CAL_OFF: res = {1'b0, MR4_CAL_V0};
			MR4_CAL_C3: res = {1'b0, MR4_CAL_V3};
			MR4_CAL_C4: res = {1'b0, MR4_CAL_V4};
			MR4_CAL_C5: res = {1'b0, MR4_CAL_V5};
			MR4_CAL_C6: res = {1'b0, MR4_CAL_V6};
			MR4_CAL_C8: res = {1'b0, MR4_CAL_V8};
			default: res = {1'b1, MR4_CAL_V0};
		endcase
		return res;
	endfunction : mr4_cal_decode

	// ------------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------------
	logic [MR4_PIN_W-1:0] pins_raw;
	logic [MR4_PIN_W-1:0] pins_s;
	logic cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s;
	logic [MR4_BG_W-1:0] bg_s;
	logic [MR4_BA_W-1:0] ba_s;
	logic a17_s;
	logic [MR4_ADDR_W-1:0] addr_s;
	logic power_down_s;

	assign pins_raw = {pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n,
		pin_bg, pin_ba, pin_a17, pin_addr, pin_power_down};

	// idle value keeps strobes high so reset never looks like a command
	mr4_sync #(
		.W(MR4_PIN_W),
		.RST_VAL(MR4_PIN_IDLE)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d(pins_raw),
		.q(pins_s)
	);

	assign {cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s,
		bg_s, ba_s, a17_s, addr_s, power_down_s} = pins_s;

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------
	logic is_mode_set;
	logic is_write_cmd;
	logic [MR4_IMG_W-1:0] image;
	logic [2:0] sel;
	logic load;

	// the controller keeps all three strobes low for mode-set
	assign is_mode_set = !cs_n_s && act_n_s && !ras_n_s && !cas_n_s && !we_n_s;
	assign is_write_cmd = !cs_n_s && act_n_s && ras_n_s && !cas_n_s && !we_n_s;

	// bits 16:14 are the strobe pins and carry no data
	assign image = {bg_s, ba_s, a17_s, 3'h0, addr_s};
	assign sel = image[MR4_B_SEL_HI:MR4_B_SEL_LO];
	assign load = is_mode_set && (sel == MR4_SEL_THIS);

	// ------------------------------------------------------------------
	// register image and decoded controls
	// ------------------------------------------------------------------
	logic [MR4_IMG_W-1:0] img_reg, img_next;
	logic perm_reg, perm_next;
	logic soft_reg, soft_next;
	logic wr_lead_reg, wr_lead_next;
	logic rd_lead_reg, rd_lead_next;
	logic rd_train_reg, rd_train_next;
	logic sr_abort_reg, sr_abort_next;
	logic [MR4_CAL_VAL_W-1:0] cal_reg, cal_next;
	logic cal_rsv_reg, cal_rsv_next;
	logic vref_reg, vref_next;
	logic tcr_reg, tcr_next;
	logic tcr_ext_reg, tcr_ext_next;
	logic max_pwr_reg, max_pwr_next;
	logic load_reg, load_next;
	logic rsv_seen_reg, rsv_seen_next;
	logic dnu_seen_reg, dnu_seen_next;
	logic [MR4_CAL_VAL_W:0] cal_dec;

	always_comb begin
		img_next = img_reg;
		if (load) begin
			img_next = image;
		end
		cal_dec = mr4_cal_decode(img_next[MR4_B_CAL_HI:MR4_B_CAL_LO]);
		perm_next = img_next[MR4_B_PERM_REPAIR];
		wr_lead_next = img_next[MR4_B_WR_LEAD];
		rd_lead_next = img_next[MR4_B_RD_LEAD];
		rd_train_next = img_next[MR4_B_RD_TRAIN];
		sr_abort_next = img_next[MR4_B_SR_ABORT];
		cal_next = cal_dec[MR4_CAL_VAL_W-1:0];
		cal_rsv_next = cal_dec[MR4_CAL_VAL_W];
		soft_next = img_next[MR4_B_SOFT_REPAIR];
		vref_next = img_next[MR4_B_VREF_MON];
		tcr_next = img_next[MR4_B_TCR_EN];
		tcr_ext_next = img_next[MR4_B_TCR_RANGE];
		max_pwr_next = img_next[MR4_B_MAX_PWR];
		load_next = load;
		// sticky marks of illegal programming; a reserved-bit load is still stored
		rsv_seen_next = rsv_seen_reg;
		if (load && (image[MR4_B_RSV21] || image[MR4_B_RSV17] || image[MR4_B_RSV0])) begin
			rsv_seen_next = 1'b1;
		end
		dnu_seen_next = dnu_seen_reg;
		if (is_mode_set && (sel == MR4_SEL_FORBIDDEN)) begin
			dnu_seen_next = 1'b1;
		end
		if (rst) begin
			img_next = MR4_RESET_IMG;
			perm_next = 1'b0;
			wr_lead_next = 1'b0;
			rd_lead_next = 1'b0;
			rd_train_next = 1'b0;
			sr_abort_next = 1'b0;
			cal_next = MR4_CAL_V0;
			cal_rsv_next = 1'b0;
			soft_next = 1'b0;
			vref_next = 1'b0;
			tcr_next = 1'b0;
			tcr_ext_next = 1'b0;
			max_pwr_next = 1'b0;
			load_next = 1'b0;
			rsv_seen_next = 1'b0;
			dnu_seen_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		img_reg <= img_next;
		perm_reg <= perm_next;
		soft_reg <= soft_next;
		wr_lead_reg <= wr_lead_next;
		rd_lead_reg <= rd_lead_next;
		rd_train_reg <= rd_train_next;
		sr_abort_reg <= sr_abort_next;
		cal_reg <= cal_next;
		cal_rsv_reg <= cal_rsv_next;
		vref_reg <= vref_next;
		tcr_reg <= tcr_next;
		tcr_ext_reg <= tcr_ext_next;
		max_pwr_reg <= max_pwr_next;
		load_reg <= load_next;
		rsv_seen_reg <= rsv_seen_next;
		dnu_seen_reg <= dnu_seen_next;
	end

	// ------------------------------------------------------------------
	// readback availability byte
	// ------------------------------------------------------------------
	logic [7:0] rb_reg, rb_next;

	always_comb begin
		rb_next = 8'h00;
		rb_next[MR4_RB_B_PERM] = PERM_REPAIR_AVAIL;
		rb_next[MR4_RB_B_SOFT] = SOFT_REPAIR_AVAIL;
		if (rst) begin
			rb_next = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		rb_reg <= rb_next;
	end

	// ------------------------------------------------------------------
	// row repair
	// ------------------------------------------------------------------
	logic rep_req;
	logic rep_soft;

	// permanent mode takes priority when both modes are on; an absent
	// feature never repairs, whatever the register says
	assign rep_req = is_write_cmd && ((perm_reg && PERM_REPAIR_AVAIL) ||
		(soft_reg && SOFT_REPAIR_AVAIL));
	assign rep_soft = !(perm_reg && PERM_REPAIR_AVAIL);

	mr4_repair #(
		.BG_N(BG_N),
		.ROW_W(MR4_ADDR_W)
	) u_repair (
		.clk(clk),
		.rst(rst),
		.por(por),
		.power_down(power_down_s),
		.req(rep_req),
		.req_soft(rep_soft),
		.req_bg(bg_s),
		.req_row(addr_s),
		.perm_mask(perm_repaired),
		.soft_mask(soft_repaired),
		.perm_rows(),
		.soft_rows(),
		.refused(repair_refused)
	);

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign mode_register_four = img_reg;
	assign permanent_row_repair = perm_reg;
	assign soft_row_repair = soft_reg;
	assign write_strobe_lead_two = wr_lead_reg;
	assign read_strobe_lead_two = rd_lead_reg;
	assign read_preamble_training = rd_train_reg;
	assign self_refresh_abort = sr_abort_reg;
	assign cmd_addr_latency = cal_reg;
	assign cal_code_reserved = cal_rsv_reg;
	assign vref_monitor = vref_reg;
	assign temp_refresh = tcr_reg;
	assign temp_refresh_extended = tcr_ext_reg;
	assign max_power_saving = max_pwr_reg;
	assign readback_pattern_register = rb_reg;
	assign load_pulse = load_reg;
	assign reserved_future_bit_seen = rsv_seen_reg;
	assign forbidden_select_code_seen = dnu_seen_reg;

endmodule : mr4_top

/* mr4_ctrl_model.sv */
/*
 * Controller model for the fourth mode register: issues mode-set, write and idle
 * commands and drives the power-down pin.
 * Assumes the bench calls its tasks; pins change 1 ns after the rising clk edge.
 */
`timescale 1ns/1ps
module mr4_ctrl_model
	import mr4_pkg::*;
(
	input wire logic clk,
	output logic cs_n,
	output logic act_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [MR4_BG_W-1:0] bg,
	output logic [MR4_BA_W-1:0] ba,
	output logic a17,
	output logic [MR4_ADDR_W-1:0] addr,
	output logic power_down
);
	// ------------------------------------------------------------------
	// command tasks
	// ------------------------------------------------------------------
	// no gear-down, write latency or readback access is modelled
	initial begin
		{cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
		{bg, ba, a17, addr} = '0;
		power_down = 1'b0;
	end
	// ctl is {act_n, ras_n, cas_n, we_n}; 4'h8 is a mode-set with all three strobes low
	task send(input logic [3:0] ctl, input logic [MR4_IMG_W-1:0] img);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		{act_n, ras_n, cas_n, we_n} = ctl;
		{bg, ba, a17} = img[21:17];
		addr = img[13:0];
	endtask : send
	// deselected pins show the inverse of the last value, so a stale hold never passes
	task idle();
		@(posedge clk);
		#1;
		{cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
		{bg, ba, a17, addr} = ~{bg, ba, a17, addr};
	endtask : idle
	task pdown(input logic v);
		@(posedge clk);
		#1;
		power_down = v;
	endtask : pdown
endmodule : mr4_ctrl_model

/* mr4_top_assertions.sv */
/*
 * Checker for the fourth mode register: load timing, image, decode, flags, repairs.
 * Assumes it is bound into mr4_top and sees only its ports; pin to output is 3 edges.
 */
`timescale 1ns/1ps
module mr4_top_assertions
	import mr4_pkg::*;
#(
	parameter logic PERM_REPAIR_AVAIL = 1'b1,
	parameter logic SOFT_REPAIR_AVAIL = 1'b1,
	parameter int BG_N = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	input wire logic pin_cs_n,
	input wire logic pin_act_n,
	input wire logic pin_ras_n,
	input wire logic pin_cas_n,
	input wire logic pin_we_n,
	input wire logic [MR4_BG_W-1:0] pin_bg,
	input wire logic [MR4_BA_W-1:0] pin_ba,
	input wire logic pin_a17,
	input wire logic [MR4_ADDR_W-1:0] pin_addr,
	input wire logic pin_power_down,
	input wire logic [MR4_IMG_W-1:0] mode_register_four,
	input wire logic permanent_row_repair,
	input wire logic soft_row_repair,
	input wire logic write_strobe_lead_two,
	input wire logic read_strobe_lead_two,
	input wire logic read_preamble_training,
	input wire logic self_refresh_abort,
	input wire logic [MR4_CAL_VAL_W-1:0] cmd_addr_latency,
	input wire logic cal_code_reserved,
	input wire logic vref_monitor,
	input wire logic temp_refresh,
	input wire logic temp_refresh_extended,
	input wire logic max_power_saving,
	input wire logic [7:0] readback_pattern_register,
	input wire logic load_pulse,
	input wire logic reserved_future_bit_seen,
	input wire logic forbidden_select_code_seen,
	input wire logic [BG_N-1:0] perm_repaired,
	input wire logic [BG_N-1:0] soft_repaired
);
	// ------------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------------
	// run_reg counts edges out of reset so $past never looks into the reset span
	logic [1:0] run_reg;
	logic [1:0] run_next;
	logic mode_set, sel_hit, sel_bad;
	logic [MR4_IMG_W-1:0] pin_img;
	logic [2:0] cal;
	always_comb begin
		run_next = rst ? 2'h0 : (run_reg == 2'h3 ? run_reg : run_reg + 2'h1);
	end
	always_ff @(posedge clk) begin
		run_reg <= run_next;
	end
	assign mode_set = !pin_cs_n && pin_act_n && !pin_ras_n && !pin_cas_n && !pin_we_n;
	assign sel_hit = mode_set && {pin_bg[0], pin_ba} == 3'h4;
	assign sel_bad = mode_set && {pin_bg[0], pin_ba} == 3'h7;
	assign pin_img = {pin_bg, pin_ba, pin_a17, 3'h0, pin_addr};
	assign cal = mode_register_four[8:6];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_LOAD: assert property (sel_hit |-> ##3 load_pulse)
		else $error("mode-set to this register did not load");
	AST_ONLY: assert property (load_pulse |-> run_reg == 2'h3 && $past(sel_hit, 3))
		else $error("load without a matching mode-set");
	AST_IMAGE: assert property (load_pulse |-> mode_register_four == $past(pin_img, 3))
		else $error("image does not match the pins");
	AST_HOLD: assert property (!load_pulse |-> $stable(mode_register_four))
		else $error("image changed without a load");
	AST_FIELDS: assert property ({permanent_row_repair, write_strobe_lead_two, read_strobe_lead_two,
		read_preamble_training, self_refresh_abort, soft_row_repair, vref_monitor, temp_refresh,
		temp_refresh_extended, max_power_saving} == {mode_register_four[13:9],
		mode_register_four[5:1]})
		else $error("field outputs differ from image");
	AST_CAL: assert property (cmd_addr_latency == ((cal == 3'h0 || cal > 3'h5) ? 4'h0 :
		(cal == 3'h5 ? 4'h8 : {1'b0, cal} + 4'h2)) && cal_code_reserved == (cal[2:1] == 2'h3))
		else $error("latency decode wrong");
	AST_READBACK: assert property (run_reg == 2'h3 |->
		readback_pattern_register == {PERM_REPAIR_AVAIL, SOFT_REPAIR_AVAIL, 6'h0})
		else $error("readback byte wrong");
	AST_FORBID: assert property (sel_bad |-> ##3 forbidden_select_code_seen)
		else $error("forbidden select not flagged");
	AST_RSV: assert property (load_pulse && (mode_register_four[21] || mode_register_four[17] ||
		mode_register_four[0]) |-> ##[0:1] reserved_future_bit_seen)
		else $error("reserved bit load not flagged");
	AST_PERM_KEEP: assert property (@(posedge clk) disable iff (por)
		1'b1 |=> (perm_repaired & $past(perm_repaired)) == $past(perm_repaired))
		else $error("permanent repair was lost");
	AST_SOFT_OFF: assert property (pin_power_down |-> ##3 soft_repaired == '0)
		else $error("soft repair survived power-down");
	cover property (load_pulse ##1 load_pulse);
	cover property (cal_code_reserved);
	cover property (pin_power_down && |soft_repaired);
endmodule : mr4_top_assertions

bind mr4_top mr4_top_assertions #(.PERM_REPAIR_AVAIL(PERM_REPAIR_AVAIL), .SOFT_REPAIR_AVAIL(SOFT_REPAIR_AVAIL),
	.BG_N(BG_N)) u_chk (.clk(clk), .rst(rst), .por(por), .pin_cs_n(pin_cs_n), .pin_act_n(pin_act_n),
	.pin_ras_n(pin_ras_n), .pin_cas_n(pin_cas_n), .pin_we_n(pin_we_n), .pin_bg(pin_bg), .pin_ba(pin_ba),
	.pin_a17(pin_a17), .pin_addr(pin_addr), .pin_power_down(pin_power_down),
	.mode_register_four(mode_register_four), .permanent_row_repair(permanent_row_repair),
	.soft_row_repair(soft_row_repair), .write_strobe_lead_two(write_strobe_lead_two),
	.read_strobe_lead_two(read_strobe_lead_two), .read_preamble_training(read_preamble_training),
	.self_refresh_abort(self_refresh_abort), .cmd_addr_latency(cmd_addr_latency),
	.cal_code_reserved(cal_code_reserved), .vref_monitor(vref_monitor), .temp_refresh(temp_refresh),
	.temp_refresh_extended(temp_refresh_extended), .max_power_saving(max_power_saving),
	.readback_pattern_register(readback_pattern_register), .load_pulse(load_pulse),
	.reserved_future_bit_seen(reserved_future_bit_seen), .forbidden_select_code_seen(forbidden_select_code_seen),
	.perm_repaired(perm_repaired), .soft_repaired(soft_repaired));

/* mr4_top_tb.sv */
/*
 * Self-checking bench for the fourth mode register: loads, decode, select codes,
 * reserved bits, back-to-back loads, repairs, power-down, reset and power-on.
 * Assumes the controller model drives all pins; outputs settle 3 edges after pins.
 */
`timescale 1ns/1ps
module mr4_top_tb;
	import mr4_pkg::*;
	logic clk, rst, por, pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n, pin_a17, pin_power_down;
	logic [1:0] pin_bg, pin_ba;
	logic [MR4_ADDR_W-1:0] pin_addr;
	logic [MR4_IMG_W-1:0] mode_register_four, img;
	logic permanent_row_repair, soft_row_repair, write_strobe_lead_two, read_strobe_lead_two;
	logic read_preamble_training, self_refresh_abort, cal_code_reserved, vref_monitor, temp_refresh;
	logic temp_refresh_extended, max_power_saving, load_pulse, reserved_future_bit_seen;
	logic forbidden_select_code_seen, repair_refused;
	logic [3:0] cmd_addr_latency, perm_repaired, soft_repaired;
	logic [7:0] readback_pattern_register;
	logic [9:0] fields;
	int mismatches = 0;
	int checks = 0;
	int fbit [10] = '{13, 12, 11, 10, 9, 5, 4, 3, 2, 1};
	logic [3:0] exp_cal [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h0};
	assign fields = {permanent_row_repair, write_strobe_lead_two, read_strobe_lead_two, read_preamble_training,
		self_refresh_abort, soft_row_repair, vref_monitor, temp_refresh, temp_refresh_extended, max_power_saving};
	always #12.5 clk = ~clk;
	mr4_ctrl_model u_ctrl (.clk(clk), .cs_n(pin_cs_n), .act_n(pin_act_n), .ras_n(pin_ras_n), .cas_n(pin_cas_n),
		.we_n(pin_we_n), .bg(pin_bg), .ba(pin_ba), .a17(pin_a17), .addr(pin_addr), .power_down(pin_power_down));
	mr4_top u_dut (.clk(clk), .rst(rst), .por(por), .pin_cs_n(pin_cs_n), .pin_act_n(pin_act_n),
		.pin_ras_n(pin_ras_n), .pin_cas_n(pin_cas_n), .pin_we_n(pin_we_n), .pin_bg(pin_bg), .pin_ba(pin_ba),
		.pin_a17(pin_a17), .pin_addr(pin_addr), .pin_power_down(pin_power_down),
		.mode_register_four(mode_register_four), .permanent_row_repair(permanent_row_repair),
		.soft_row_repair(soft_row_repair), .write_strobe_lead_two(write_strobe_lead_two),
		.read_strobe_lead_two(read_strobe_lead_two), .read_preamble_training(read_preamble_training),
		.self_refresh_abort(self_refresh_abort), .cmd_addr_latency(cmd_addr_latency),
		.cal_code_reserved(cal_code_reserved), .vref_monitor(vref_monitor), .temp_refresh(temp_refresh),
		.temp_refresh_extended(temp_refresh_extended), .max_power_saving(max_power_saving),
		.readback_pattern_register(readback_pattern_register), .load_pulse(load_pulse),
		.reserved_future_bit_seen(reserved_future_bit_seen), .forbidden_select_code_seen(forbidden_select_code_seen),
		.perm_repaired(perm_repaired), .soft_repaired(soft_repaired), .repair_refused(repair_refused));
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// one command then idle; returns just after the edge where its outputs land
	task automatic wr(input logic [3:0] ctl, input logic [MR4_IMG_W-1:0] m);
		u_ctrl.send(ctl, m);
		u_ctrl.idle();
		repeat (2) @(posedge clk);
		#1;
	endtask : wr
	task automatic reset_pulse(input logic p);
		@(posedge clk);
		#1;
		rst = 1'b1;
		por = p;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		por = 1'b0;
		@(posedge clk);
		#1;
	endtask : reset_pulse
	task results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	// about 160 cycles of tests; the limit leaves a wide margin
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		por = 1'b1;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		por = 1'b0;
		@(posedge clk);
		#1;
		chk(mode_register_four, 22'h0, "reset image");
		chk(readback_pattern_register, 8'hc0, "readback byte");
		$display("test reset done");
		foreach (fbit[i]) begin
			img = 22'h100000 | (22'h1 << fbit[i]);
			wr(4'h8, img);
			chk(load_pulse, 1'b1, "load pulse");
			chk(mode_register_four, img, "image");
			chk(fields, {img[13:9], img[5:1]}, "fields");
		end
		$display("test fields done");
		for (int c = 0; c < 8; c++) begin
			img = 22'h100000 | (22'(c) << 6);
			wr(4'h8, img);
			chk(cmd_addr_latency, exp_cal[c], "latency");
			chk(cal_code_reserved, 1'(c > 5), "latency reserved");
		end
		$display("test latency done");
		for (int s = 0; s < 8; s++) begin
			if (s != 4) begin
				wr(4'h8, (22'(s) << 18) | 22'h02aaa);
				chk(load_pulse, 1'b0, "foreign select pulse");
				chk(mode_register_four, img, "foreign select image");
				chk(forbidden_select_code_seen, 1'(s == 7), "forbidden flag");
			end
		end
		wr(4'h9, 22'h102aaa);
		chk(mode_register_four, img, "not a mode-set");
		wr(4'hc, 22'h200123);
		chk(perm_repaired, 4'h0, "write outside repair mode");
		$display("test select done");
		u_ctrl.send(4'h8, 22'h320001);
		u_ctrl.send(4'h8, 22'h102aaa);
		u_ctrl.idle();
		@(posedge clk);
		#1;
		chk(mode_register_four, 22'h320001, "first of pair");
		chk(reserved_future_bit_seen, 1'b1, "reserved flag");
		@(posedge clk);
		#1;
		chk(load_pulse, 1'b1, "second pulse");
		chk(mode_register_four, 22'h102aaa, "second of pair");
		$display("test back to back done");
		wr(4'hc, 22'h200123);
		chk(perm_repaired, 4'h4, "permanent repair");
		wr(4'hc, 22'h200456);
		chk(repair_refused, 1'b1, "second repair refused");
		wr(4'h8, 22'h100020);
		wr(4'hc, 22'h100077);
		chk(soft_repaired, 4'h2, "soft repair");
		u_ctrl.pdown(1'b1);
		u_ctrl.pdown(1'b0);
		repeat (2) @(posedge clk);
		#1;
		chk(soft_repaired, 4'h0, "soft lost on power-down");
		wr(4'hc, 22'h100077);
		chk(soft_repaired, 4'h2, "soft again");
		reset_pulse(1'b0);
		chk(soft_repaired, 4'h0, "soft lost on reset");
		chk(perm_repaired, 4'h4, "permanent kept");
		chk(mode_register_four, 22'h0, "image cleared");
		reset_pulse(1'b1);
		chk(perm_repaired, 4'h0, "power-on clears");
		$display("test repair done");
		results();
	end
endmodule : mr4_top_tb
